// ### common/tmk_alert_if.sv
`timescale 1ns/1ps
`default_nettype none
interface tmk_alert_if;
	logic [7:0] ctrl;
	logic key_err;
	logic press;
	logic sleep;
	logic nvm_err;
	logic mains_err;
	logic comms_bad;
	logic get_last;
	logic host_cmd;
	logic host_act;
	logic tick;
	logic alert;
	modport core(output ctrl, key_err, press, sleep, nvm_err, mains_err,
		comms_bad, get_last, host_cmd, host_act, tick, input alert);
	modport pin(input ctrl, key_err, press, sleep, nvm_err, mains_err,
		comms_bad, get_last, host_cmd, host_act, tick, output alert);
endinterface
`default_nettype wire

// ### common/tmk_pkg.sv
`default_nettype none
package tmk_pkg;
	localparam int NKEYS = 48;
	localparam int BLOCK_LEN = 247;
	localparam logic [7:0] OFS_THR = 8'h00;
	localparam logic [7:0] OFS_DRIFT = 8'h30;
	localparam logic [7:0] OFS_DIL = 8'h60;
	localparam logic [7:0] OFS_NRD = 8'h90;
	localparam logic [7:0] OFS_OPT = 8'hc0;
	localparam logic [7:0] OFS_GLOB = 8'hf0;
	localparam logic [7:0] OFS_SPACE = 8'hf1;
	localparam logic [7:0] OFS_LSL = 8'hf2;
	localparam logic [7:0] OFS_ALERT = 8'hf4;
	localparam logic [7:0] OFS_CRC = 8'hf5;
	localparam logic [7:0] OFS_LAST = 8'hf6;
	localparam logic [4:0] THR_BIAS = 5'h04;
	localparam logic [7:0] THR_RST = 8'h26;
	localparam logic [7:0] DRIFT_RST = 8'h4a;
	localparam logic [7:0] DIL_RST = 8'h52;
	localparam logic [7:0] NRD_RST = 8'h14;
	localparam logic [7:0] OPT_RST = 8'h26;
	localparam logic [7:0] GLOB_RST = 8'h11;
	localparam logic [7:0] SPACE_RST = 8'h00;
	localparam logic [15:0] LSL_RST = 16'h0064;
	localparam logic [7:0] ALERT_RST = 8'h6c;
	localparam int BL_LSB = 4;
	localparam int AKS_BIT = 6;
	localparam int SCOPE_TRIGGER_ENABLE_BIT = 7;
	localparam int DWELL_LSB = 4;
	localparam int MAINS_LOCK_ENABLE_BIT = 6;
	localparam int AL_POL = 7;
	localparam int AL_KERR = 6;
	localparam int AL_PRESS = 5;
	localparam int AL_SLEEP = 4;
	localparam int AL_NVM = 3;
	localparam int AL_MAINS = 2;
	localparam int AL_COMMS = 1;
	localparam int AL_WDOG = 0;
	localparam logic [7:0] CMD_SETUPS_ENTER = 8'h01;
	localparam logic [7:0] CMD_REPORT_KEYS = 8'h07;
	localparam logic [15:0] CRC_POLY_DEF = 16'h1021;
	localparam logic [15:0] CRC_INIT_DEF = 16'h0000;
	localparam longint CLK_HZ = 200000000;
	localparam int TICK_MS = 1;
	localparam int TICK_CYCLES_DEF = int'(CLK_HZ * TICK_MS / 1000);
	localparam int WDOG_MS = 2000;
	localparam int HRST_MS = 150;
	localparam int MAINS_MS = 100;
	localparam int MS_W = 12;
endpackage
`default_nettype wire

// ### dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	import tmk_pkg::*;
	logic core_clk_i, nrst_i, cold_start_i, key_signal_valid_i, cal_error_i;
	logic sleep_i, nvm_error_i, mains_sync_i, scan_done_i;
	logic [5:0] key_sel_i, key_signal_key_i;
	logic [15:0] key_signal_i, lower_signal_limit_o;
	logic [47:0] key_touch_i, key_low_signal_o, q;
	logic host_cmd_valid_i, host_cmd_bad_i, host_get_last_i, setup_valid_i;
	logic [7:0] host_cmd_i, setup_byte_i, neg_recal_delay_o, report_byte_o;
	logic report_ready_i, setups_mode_o, setup_refused_o, setup_done_o, ok;
	logic setup_crc_err_o, block_valid_o, key_burst_enable_o, alert_o;
	logic adjacent_key_suppression_o, scope_trigger_enable_o, report_valid_o;
	logic mains_lock_enable_o, mains_sync_error_o;
	logic [4:0] neg_touch_threshold_o, pos_touch_threshold_o;
	logic [3:0] neg_drift_rate_o, pos_drift_rate_o, normal_integrator_limit_o;
	logic [3:0] fast_integrator_limit_o, pos_recal_delay_o, release_hysteresis_o;
	logic [3:0] burst_spacing_o, uart_baud_select_o;
	logic [1:0] burst_pulse_count_o, dwell_select_o;
	logic [42:0] pko;
	logic [30:0] glo;
	int errors, n_checks, n;
	assign pko = {neg_touch_threshold_o, pos_touch_threshold_o,
		neg_drift_rate_o, pos_drift_rate_o, normal_integrator_limit_o,
		fast_integrator_limit_o, key_burst_enable_o, neg_recal_delay_o,
		pos_recal_delay_o, burst_pulse_count_o, adjacent_key_suppression_o,
		scope_trigger_enable_o};
	assign glo = {release_hysteresis_o, dwell_select_o, mains_lock_enable_o,
		burst_spacing_o, uart_baud_select_o, lower_signal_limit_o};
	tmk_setups #(.TICK_CYCLES(4)) dut (.core_clk_i, .nrst_i, .cold_start_i,
		.host_cmd_valid_i, .host_cmd_i, .host_cmd_bad_i, .host_get_last_i,
		.setup_valid_i, .setup_byte_i, .key_sel_i, .key_signal_valid_i,
		.key_signal_key_i, .key_signal_i, .key_touch_i, .cal_error_i, .sleep_i,
		.nvm_error_i, .mains_sync_i, .scan_done_i, .report_ready_i,
		.setups_mode_o, .setup_refused_o, .setup_done_o, .setup_crc_err_o,
		.block_valid_o, .neg_touch_threshold_o, .pos_touch_threshold_o,
		.neg_drift_rate_o, .pos_drift_rate_o, .normal_integrator_limit_o,
		.fast_integrator_limit_o, .key_burst_enable_o, .neg_recal_delay_o,
		.pos_recal_delay_o, .burst_pulse_count_o, .adjacent_key_suppression_o,
		.scope_trigger_enable_o, .release_hysteresis_o, .dwell_select_o,
		.mains_lock_enable_o, .burst_spacing_o, .uart_baud_select_o,
		.lower_signal_limit_o, .key_low_signal_o, .mains_sync_error_o,
		.report_valid_o, .report_byte_o, .alert_o);
	tmk_host_model host (.core_clk_i, .report_valid_i(report_valid_o),
		.report_byte_i(report_byte_o), .cmd_valid_o(host_cmd_valid_i),
		.cmd_o(host_cmd_i), .cmd_bad_o(host_cmd_bad_i),
		.get_last_o(host_get_last_i), .setup_valid_o(setup_valid_i),
		.setup_byte_o(setup_byte_i), .report_ready_o(report_ready_i));
	function automatic logic [42:0] expk(input logic [7:0] t, d, i, r, o);
		return {5'h04 + t[3:0], 5'h04 + t[7:4], d[3:0], d[7:4], i[3:0],
			i[7:4], i[3:0] != 4'h0, r, o[3:0], o[5:4], o[6], o[7]};
	endfunction
	function automatic logic [30:0] expg(input logic [7:0] g0, g1,
		input logic [15:0] l);
		return {g0[3:0], g0[5:4], g0[6], g1[3:0], g1[7:4], l};
	endfunction
	task automatic chk(input string nm, input logic [47:0] e, g);
		n_checks++;
		if (g !== e) begin
			errors++;
			$display("mismatch %s expected %0h seen %0h", nm, e, g);
		end
	endtask
	task automatic cyc(input int c);
		repeat (c) @(posedge core_clk_i);
		#1;
	endtask
	task automatic conclude();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// counts cycles until alert_o equals v, giving up after lim
	task automatic wait_alert(input logic v, input int lim);
		n = 0;
		while (alert_o !== v && n < lim) begin
			cyc(1);
			n++;
		end
		if (n >= lim) begin
			errors++;
			conclude();
		end
	endtask
	initial begin
		core_clk_i = 1'b0;
		forever #2.5 core_clk_i = ~core_clk_i;
	end
	initial begin
		repeat (30000) @(posedge core_clk_i);
		errors++;
		conclude();
	end
	initial begin
		{nrst_i, key_signal_valid_i, cal_error_i, sleep_i, nvm_error_i} = 5'h00;
		{cold_start_i, mains_sync_i, scan_done_i} = 3'h6;
		{key_sel_i, key_signal_key_i, key_signal_i, key_touch_i} = 76'h0;
		repeat (20) @(posedge core_clk_i);
		nrst_i <= 1'b1;
		cold_start_i <= 1'b0;
		cyc(2);
		chk("key dflt", expk(THR_RST, DRIFT_RST, DIL_RST, 8'h14, OPT_RST), pko);
		chk("glob dflt", expg(GLOB_RST, 8'h00, 16'h0064), glo);
		for (int i = 0; i < 4; i++) begin
			@(posedge core_clk_i);
			{key_touch_i[3], cal_error_i, nvm_error_i, sleep_i} <= 4'h8 >> i;
			cyc(3);
			chk("alert dflt", i == 3, alert_o);
		end
		@(posedge core_clk_i);
		{key_touch_i[3], sleep_i} <= 2'h0;
		host.put(8'h55);
		host.stop();
		#1;
		chk("refused", 1'b1, setup_refused_o);
		host.load(8'h63, 8'h4b, 8'hc0, 16'h0123, 1'b0);
		#1;
		chk("done", 2'h2, {setup_done_o, setup_crc_err_o});
		for (int k = 0; k < 48; k++) begin
			@(posedge core_clk_i);
			key_sel_i <= 6'(k);
			cyc(2);
			chk("key", expk(host.pk(0, k), host.pk(1, k), host.pk(2, k),
				host.pk(3, k), host.pk(4, k)), pko);
		end
		chk("glob", expg(8'h63, 8'h4b, 16'h0123), glo);
		for (int i = 0; i < 2; i++) begin
			@(posedge core_clk_i);
			key_signal_valid_i <= 1'b1;
			key_signal_key_i <= 6'h05;
			key_signal_i <= 16'h0122 + 16'(i);
			@(posedge core_clk_i);
			key_signal_valid_i <= 1'b0;
			key_signal_i <= 16'hffff;
			cyc(3);
			chk("low sig", {2{i == 0}}, {key_low_signal_o[5], alert_o});
		end
		key_touch_i <= 48'ha53c0ff0817e;
		host.report(q, ok);
		chk("report ok", 1'b1, ok);
		chk("report", key_touch_i, q);
		@(posedge core_clk_i);
		scan_done_i <= 1'b1;
		@(posedge core_clk_i);
		scan_done_i <= 1'b0;
		n = 0;
		while (mains_sync_error_o !== 1'b1 && n < 600) begin
			cyc(1);
			n++;
		end
		chk("mains wait", 1'b1, n inside {[390:410]});
		@(posedge core_clk_i);
		mains_sync_i <= 1'b0;
		cyc(3);
		chk("mains clr", 1'b0, mains_sync_error_o);
		host.load(8'h11, 8'h00, 8'h03, 16'h0200, 1'b1);
		#1;
		chk("crc bad", 2'h1, {setup_done_o, setup_crc_err_o});
		chk("glob kept", expg(8'h63, 8'h4b, 16'h0123), glo);
		host.load(8'h11, 8'h00, 8'h03, 16'h0200, 1'b0);
		host.cmd(8'h00, 1);
		cyc(2);
		chk("comms set", 1'b0, alert_o);
		host.cmd(8'h00, 2);
		cyc(2);
		chk("comms clr", 1'b1, alert_o);
		wait_alert(1'b0, 8200);
		chk("wdog idle", 1'b1, n inside {[7990:8010]});
		wait_alert(1'b1, 700);
		chk("wdog pulse", 1'b1, n inside {[596:604]});
		@(posedge core_clk_i);
		nrst_i <= 1'b0;
		cyc(3);
		nrst_i <= 1'b1;
		cyc(2);
		chk("retained", 17'h10200, {block_valid_o, lower_signal_limit_o});
		n = 0;
		repeat (9000) begin
			cyc(1);
			n += (alert_o !== 1'b1);
		end
		chk("wdog disarmed", 0, n);
		conclude();
	end
endmodule
`default_nettype wire

// ### dv/tmk_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module tmk_host_model (
	input wire logic core_clk_i,
	input wire logic report_valid_i,
	input wire logic [7:0] report_byte_i,
	output logic cmd_valid_o,
	output logic [7:0] cmd_o,
	output logic cmd_bad_o,
	output logic get_last_o,
	output logic setup_valid_o,
	output logic [7:0] setup_byte_o,
	output logic report_ready_o
);
	import tmk_pkg::*;
	initial begin
		{cmd_valid_o, cmd_bad_o, get_last_o, setup_valid_o} = 4'h0;
		{cmd_o, setup_byte_o} = 16'h0000;
		report_ready_o = 1'b0;
	end
	function automatic logic [7:0] pk(input int s, input int k);
		logic [7:0] v;
		v = 8'(k * 7 + s * 29 + 1);
		if (s == 2) v[4] = 1'b1;
		if (s == 3) v[7] = 1'b0;
		return v;
	endfunction
	// kind 0 recognised, 1 unrecognised, 2 get-last request
	task automatic cmd(input logic [7:0] c, input int kind);
		@(posedge core_clk_i);
		cmd_valid_o <= (kind == 0);
		cmd_bad_o <= (kind == 1);
		get_last_o <= (kind == 2);
		cmd_o <= c;
		@(posedge core_clk_i);
		{cmd_valid_o, cmd_bad_o, get_last_o} <= 3'h0;
		cmd_o <= ~c;
	endtask
	task automatic put(input logic [7:0] b);
		@(posedge core_clk_i);
		setup_valid_o <= 1'b1;
		setup_byte_o <= b;
	endtask
	task automatic stop();
		@(posedge core_clk_i);
		setup_valid_o <= 1'b0;
		setup_byte_o <= ~setup_byte_o;
	endtask
	task automatic load(input logic [7:0] g0, g1, al, input logic [15:0] l,
		input logic bad);
		logic [15:0] crc;
		logic [7:0] b;
		logic [7:0] gl [5];
		gl = '{g0, g1, l[7:0], l[15:8], al};
		crc = CRC_INIT_DEF;
		cmd(CMD_SETUPS_ENTER, 0);
		cmd(CMD_SETUPS_ENTER, 0);
		for (int i = 0; i < 245; i++) begin
			b = (i < 240) ? pk(i / 48, i % 48) : gl[i - 240];
			put(b);
			crc = crc ^ {b, 8'h00};
			for (int j = 0; j < 8; j++)
				crc = crc[15] ? (crc << 1) ^ CRC_POLY_DEF : crc << 1;
		end
		crc[0] = crc[0] ^ bad;
		put(crc[7:0]);
		put(crc[15:8]);
		stop();
	endtask
	// slow consumer: stalls before taking some bytes
	task automatic report(output logic [47:0] q, output logic ok);
		int n;
		ok = 1'b1;
		cmd(CMD_REPORT_KEYS, 0);
		for (int i = 0; i < 6; i++) begin
			n = 0;
			do begin
				@(posedge core_clk_i);
				n++;
			end while (report_valid_i !== 1'b1 && n < 20);
			if (n == 20) ok = 1'b0;
			repeat (i % 3) @(posedge core_clk_i);
			report_ready_o <= 1'b1;
			@(posedge core_clk_i);
			q[8 * i +: 8] = report_byte_i;
			report_ready_o <= 1'b0;
		end
	endtask
endmodule
`default_nettype wire

// ### dv/tmk_setups_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module tmk_setups_chk (
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input wire logic setup_valid_i,
	input wire logic host_cmd_valid_i,
	input wire logic [7:0] host_cmd_i,
	input wire logic setups_mode_o,
	input wire logic setup_refused_o,
	input wire logic setup_done_o,
	input wire logic setup_crc_err_o,
	input wire logic [4:0] pos_touch_threshold_o,
	input wire logic [3:0] normal_integrator_limit_o,
	input wire logic key_burst_enable_o,
	input wire logic report_valid_o,
	input wire logic report_ready_i,
	input wire logic [7:0] report_byte_o,
	input wire logic [47:0] key_touch_i,
	input wire logic key_signal_valid_i,
	input wire logic [5:0] key_signal_key_i,
	input wire logic [15:0] key_signal_i,
	input wire logic [15:0] lower_signal_limit_o,
	input wire logic [47:0] key_low_signal_o,
	input wire logic mains_sync_error_o,
	input wire logic mains_lock_enable_o
);
	import tmk_pkg::*;
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!nrst_i);
	sequence s_idle_byte;
		setup_valid_i && !setups_mode_o;
	endsequence
	sequence s_last_byte;
		setups_mode_o && setup_valid_i;
	endsequence
	property p_refuse;
		s_idle_byte |=> setup_refused_o;
	endproperty
	a_refuse: assert property (p_refuse) else $error("byte not refused");
	property p_refuse_cause;
		setup_refused_o |-> $past(!setups_mode_o && setup_valid_i);
	endproperty
	a_refuse_cause: assert property (p_refuse_cause)
		else $error("refusal without idle byte");
	property p_enter;
		$rose(setups_mode_o)
			|-> $past(host_cmd_valid_i && host_cmd_i == CMD_SETUPS_ENTER);
	endproperty
	a_enter: assert property (p_enter) else $error("mode without entry");
	property p_end;
		setup_done_o || setup_crc_err_o
			|-> !setups_mode_o && $past(setups_mode_o && setup_valid_i);
	endproperty
	a_end: assert property (p_end) else $error("block end out of place");
	property p_thr;
		pos_touch_threshold_o != 5'h00 |-> pos_touch_threshold_o inside {[4:19]};
	endproperty
	a_thr: assert property (p_thr) else $error("threshold out of range");
	property p_burst;
		key_burst_enable_o == (normal_integrator_limit_o != 4'h0);
	endproperty
	a_burst: assert property (p_burst) else $error("burst enable wrong");
	property p_hold;
		report_valid_o && !report_ready_i
			|=> report_valid_o && $stable(report_byte_o);
	endproperty
	a_hold: assert property (p_hold) else $error("report byte dropped");
	property p_first;
		$rose(report_valid_o) |-> report_byte_o == $past(key_touch_i[7:0]);
	endproperty
	a_first: assert property (p_first) else $error("first byte wrong");
	property p_low;
		key_signal_valid_i ##1 1'b1 |-> key_low_signal_o[$past(key_signal_key_i)]
			== ($past(key_signal_i) < $past(lower_signal_limit_o));
	endproperty
	a_low: assert property (p_low) else $error("low signal flag wrong");
	property p_mains;
		$rose(mains_sync_error_o) |-> mains_lock_enable_o;
	endproperty
	a_mains: assert property (p_mains) else $error("mains error unasked");
endmodule
bind tmk_setups tmk_setups_chk u_chk (.core_clk_i, .nrst_i, .setup_valid_i,
	.host_cmd_valid_i, .host_cmd_i, .setups_mode_o, .setup_refused_o,
	.setup_done_o, .setup_crc_err_o, .pos_touch_threshold_o,
	.normal_integrator_limit_o, .key_burst_enable_o, .report_valid_o,
	.report_ready_i, .report_byte_o, .key_touch_i, .key_signal_valid_i,
	.key_signal_key_i, .key_signal_i, .lower_signal_limit_o,
	.key_low_signal_o, .mains_sync_error_o, .mains_lock_enable_o);
`default_nettype wire

// ### rtl/tmk_alert.sv
`timescale 1ns/1ps
`default_nettype none
module tmk_alert (
	input wire logic core_clk_i,
	input wire logic nrst_i,
	tmk_alert_if.pin al
);
	import tmk_pkg::*;
	logic comms_latch;
	logic wd_armed;
	logic [MS_W-1:0] idle_ms;
	logic [MS_W-1:0] pulse_ms;
	logic active;

	// set wins over the get-last clear
	always_ff @(posedge core_clk_i) begin
		if (!nrst_i)
			comms_latch <= 1'b0;
		else if (al.comms_bad)
			comms_latch <= 1'b1;
		else if (al.get_last)
			comms_latch <= 1'b0;
	end

	always_ff @(posedge core_clk_i) begin
		if (!nrst_i)
			wd_armed <= 1'b0;
		else if (al.host_cmd)
			wd_armed <= 1'b1;
	end

	// idle time restarts on host commands, bad commands and setup bytes, but not on a get-last request
	always_ff @(posedge core_clk_i) begin
		if (!nrst_i || al.host_act || !wd_armed) begin
			idle_ms <= '0;
		end else if (al.tick) begin
			if (idle_ms == MS_W'(WDOG_MS - 1))
				idle_ms <= '0;
			else
				idle_ms <= idle_ms + 1'b1;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			pulse_ms <= '0;
		end else if (al.tick) begin
			if (wd_armed && al.ctrl[AL_WDOG] && !al.host_act &&
				idle_ms == MS_W'(WDOG_MS - 1))
				pulse_ms <= MS_W'(HRST_MS);
			else if (pulse_ms != '0)
				pulse_ms <= pulse_ms - 1'b1;
		end
	end

	always_comb begin
		active = (al.ctrl[AL_KERR] && al.key_err) ||
			(al.ctrl[AL_PRESS] && al.press) ||
			(al.ctrl[AL_SLEEP] && al.sleep) ||
			(al.ctrl[AL_NVM] && al.nvm_err) ||
			(al.ctrl[AL_MAINS] && al.mains_err) ||
			(al.ctrl[AL_COMMS] && comms_latch) ||
			(pulse_ms != '0);
	end

	always_ff @(posedge core_clk_i) begin
		if (!nrst_i)
			al.alert <= !ALERT_RST[AL_POL];
		else
			al.alert <= al.ctrl[AL_POL] ? active : !active;
	end
endmodule
`default_nettype wire

// ### rtl/tmk_report.sv
`timescale 1ns/1ps
`default_nettype none
module tmk_report (
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input wire logic start_i,
	input wire logic [tmk_pkg::NKEYS-1:0] flags_i,
	input wire logic ready_i,
	output logic valid_o,
	output logic [7:0] byte_o
);
	import tmk_pkg::*;
	localparam int NBYTES = NKEYS / 8;
	logic [NKEYS-1:0] snap;
	logic [2:0] idx;

	// snapshot keeps the six bytes coherent while the host drains them
	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			valid_o <= 1'b0;
			byte_o <= 8'h00;
			idx <= '0;
			snap <= '0;
		end else if (!valid_o || ready_i) begin
			if (valid_o && idx == 3'(NBYTES)) begin
				valid_o <= 1'b0;
			end else if (valid_o) begin
				byte_o <= snap[8*idx +: 8];
				idx <= idx + 1'b1;
			end else if (start_i) begin
				snap <= flags_i;
				byte_o <= flags_i[7:0];
				idx <= 3'h1;
				valid_o <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// ### rtl/tmk_setups.sv
`timescale 1ns/1ps
`default_nettype none
module tmk_setups #(
	parameter int TICK_CYCLES = tmk_pkg::TICK_CYCLES_DEF,
	parameter logic [15:0] CRC_POLY = tmk_pkg::CRC_POLY_DEF,
	parameter logic [15:0] CRC_INIT = tmk_pkg::CRC_INIT_DEF
) (
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input wire logic cold_start_i,
	input wire logic host_cmd_valid_i,
	input wire logic [7:0] host_cmd_i,
	input wire logic host_cmd_bad_i,
	input wire logic host_get_last_i,
	input wire logic setup_valid_i,
	input wire logic [7:0] setup_byte_i,
	input wire logic [5:0] key_sel_i,
	input wire logic key_signal_valid_i,
	input wire logic [5:0] key_signal_key_i,
	input wire logic [15:0] key_signal_i,
	input wire logic [tmk_pkg::NKEYS-1:0] key_touch_i,
	input wire logic cal_error_i,
	input wire logic sleep_i,
	input wire logic nvm_error_i,
	input wire logic mains_sync_i,
	input wire logic scan_done_i,
	input wire logic report_ready_i,
	output logic setups_mode_o,
	output logic setup_refused_o,
	output logic setup_done_o,
	output logic setup_crc_err_o,
	output logic block_valid_o,
	output logic [4:0] neg_touch_threshold_o,
	output logic [4:0] pos_touch_threshold_o,
	output logic [3:0] neg_drift_rate_o,
	output logic [3:0] pos_drift_rate_o,
	output logic [3:0] normal_integrator_limit_o,
	output logic [3:0] fast_integrator_limit_o,
	output logic key_burst_enable_o,
	output logic [7:0] neg_recal_delay_o,
	output logic [3:0] pos_recal_delay_o,
	output logic [1:0] burst_pulse_count_o,
	output logic adjacent_key_suppression_o,
	output logic scope_trigger_enable_o,
	output logic [3:0] release_hysteresis_o,
	output logic [1:0] dwell_select_o,
	output logic mains_lock_enable_o,
	output logic [3:0] burst_spacing_o,
	output logic [3:0] uart_baud_select_o,
	output logic [15:0] lower_signal_limit_o,
	output logic [tmk_pkg::NKEYS-1:0] key_low_signal_o,
	output logic mains_sync_error_o,
	output logic report_valid_o,
	output logic [7:0] report_byte_o,
	output logic alert_o
);
	import tmk_pkg::*;

	generate
		if (TICK_CYCLES < 1)
			$error("TICK_CYCLES must be at least one");
	endgenerate

	tmk_alert_if al();

	logic [7:0] stage [0:BLOCK_LEN-3];
	logic [7:0] live [0:BLOCK_LEN-3];
	logic nv_valid;
	logic entry_seen;
	logic [7:0] wr_idx;
	logic [15:0] crc;
	logic [7:0] crc_lo;
	logic [31:0] tick_cnt;
	logic tick;
	logic mains_prev;
	logic mains_wait;
	logic [MS_W-1:0] mains_ms;
	logic [7:0] glob;
	logic [7:0] space;
	logic [7:0] alert_ctrl;
	logic [15:0] minimum_signal_level;
	logic [7:0] key_ofs;
	logic setup_take;
	logic mains_fall;
	logic [7:0] thr_b, drift_b, dil_b, opt_b;

	function automatic logic [15:0] crc_step(input logic [15:0] c,
		input logic [7:0] d);
		logic [15:0] r;
		r = c ^ {d, 8'h00};
		for (int i = 0; i < 8; i++)
			r = r[15] ? ((r << 1) ^ CRC_POLY) : (r << 1);
		return r;
	endfunction

	function automatic logic [7:0] dflt(input logic [7:0] a);
		logic [7:0] r;
		r = 8'h00;
		if (a < OFS_DRIFT)
			r = THR_RST;
		else if (a < OFS_DIL)
			r = DRIFT_RST;
		else if (a < OFS_NRD)
			r = DIL_RST;
		else if (a < OFS_OPT)
			r = NRD_RST;
		else if (a < OFS_GLOB)
			r = OPT_RST;
		else if (a == OFS_GLOB)
			r = GLOB_RST;
		else if (a == OFS_SPACE)
			r = SPACE_RST;
		else if (a == OFS_LSL)
			r = LSL_RST[7:0];
		else if (a == OFS_LSL + 8'h01)
			r = LSL_RST[15:8];
		else if (a == OFS_ALERT)
			r = ALERT_RST;
		return r;
	endfunction

	// reads fall back to defaults until a block has been accepted
	function automatic logic [7:0] rd(input logic [7:0] a);
		logic [7:0] r;
		r = 8'h00;
		if (a < OFS_CRC)
			r = nv_valid ? live[a] : dflt(a);
		return r;
	endfunction

	assign setup_take = setup_valid_i && setups_mode_o;
	assign key_ofs = {2'b00, key_sel_i};
	// always_comb, not assign: the live copy read inside rd() must wake it
	always_comb begin
		glob = rd(OFS_GLOB);
		space = rd(OFS_SPACE);
		alert_ctrl = rd(OFS_ALERT);
		minimum_signal_level = {rd(OFS_LSL + 8'h01), rd(OFS_LSL)};
		thr_b = rd(OFS_THR + key_ofs);
		drift_b = rd(OFS_DRIFT + key_ofs);
		dil_b = rd(OFS_DIL + key_ofs);
		opt_b = rd(OFS_OPT + key_ofs);
	end
	assign mains_fall = mains_prev && !mains_sync_i;

	always_ff @(posedge core_clk_i) begin
		if (!nrst_i || tick_cnt == 32'(TICK_CYCLES - 1))
			tick_cnt <= '0;
		else
			tick_cnt <= tick_cnt + 1'b1;
	end

	always_ff @(posedge core_clk_i) begin
		if (!nrst_i)
			tick <= 1'b0;
		else
			tick <= tick_cnt == 32'(TICK_CYCLES - 1);
	end

	// entry needs two entry commands back to back; others break the pair
	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			entry_seen <= 1'b0;
			setups_mode_o <= 1'b0;
		end else if (host_cmd_valid_i) begin
			if (host_cmd_i == CMD_SETUPS_ENTER) begin
				entry_seen <= !entry_seen;
				setups_mode_o <= entry_seen;
			end else begin
				entry_seen <= 1'b0;
				setups_mode_o <= 1'b0;
			end
		end else if (setup_take && wr_idx == OFS_LAST) begin
			setups_mode_o <= 1'b0;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!nrst_i)
			setup_refused_o <= 1'b0;
		else
			setup_refused_o <= setup_valid_i && !setups_mode_o;
	end

	always_ff @(posedge core_clk_i) begin
		if (!nrst_i || !setups_mode_o) begin
			wr_idx <= 8'h00;
			crc <= CRC_INIT;
			crc_lo <= 8'h00;
		end else if (setup_take) begin
			wr_idx <= wr_idx + 8'h01;
			if (wr_idx < OFS_CRC)
				crc <= crc_step(crc, setup_byte_i);
			else
				crc_lo <= setup_byte_i;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (setup_take && wr_idx < OFS_CRC)
			stage[wr_idx] <= setup_byte_i;
	end

	// live copy survives nrst_i; only a cold start drops back to defaults
	always_ff @(posedge core_clk_i) begin
		if (!nrst_i && cold_start_i) begin
			nv_valid <= 1'b0;
		end else if (nrst_i && setup_take && wr_idx == OFS_LAST &&
			{setup_byte_i, crc_lo} == crc) begin
			nv_valid <= 1'b1;
			for (int i = 0; i < BLOCK_LEN - 2; i++)
				live[i] <= stage[i];
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			setup_done_o <= 1'b0;
			setup_crc_err_o <= 1'b0;
		end else begin
			setup_done_o <= setup_take && wr_idx == OFS_LAST &&
				{setup_byte_i, crc_lo} == crc;
			setup_crc_err_o <= setup_take && wr_idx == OFS_LAST &&
				{setup_byte_i, crc_lo} != crc;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!nrst_i)
			block_valid_o <= 1'b0;
		else
			block_valid_o <= nv_valid;
	end

	// per-key fields follow key_sel_i one cycle later
	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			neg_touch_threshold_o <= 5'h00;
			pos_touch_threshold_o <= 5'h00;
			neg_drift_rate_o <= 4'h0;
			pos_drift_rate_o <= 4'h0;
			normal_integrator_limit_o <= 4'h0;
			fast_integrator_limit_o <= 4'h0;
			key_burst_enable_o <= 1'b0;
		end else begin
			neg_touch_threshold_o <= {1'b0, thr_b[3:0]} + THR_BIAS;
			pos_touch_threshold_o <= {1'b0, thr_b[7:4]} + THR_BIAS;
			neg_drift_rate_o <= drift_b[3:0];
			pos_drift_rate_o <= drift_b[7:4];
			normal_integrator_limit_o <= dil_b[3:0];
			fast_integrator_limit_o <= dil_b[7:4];
			key_burst_enable_o <= dil_b[3:0] != 4'h0;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			neg_recal_delay_o <= NRD_RST;
			pos_recal_delay_o <= 4'h0;
			burst_pulse_count_o <= 2'h0;
			adjacent_key_suppression_o <= 1'b0;
			scope_trigger_enable_o <= 1'b0;
		end else begin
			neg_recal_delay_o <= rd(OFS_NRD + key_ofs);
			pos_recal_delay_o <= opt_b[3:0];
			burst_pulse_count_o <= opt_b[BL_LSB +: 2];
			adjacent_key_suppression_o <= opt_b[AKS_BIT];
			scope_trigger_enable_o <= opt_b[SCOPE_TRIGGER_ENABLE_BIT];
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			release_hysteresis_o <= GLOB_RST[3:0];
			dwell_select_o <= GLOB_RST[DWELL_LSB +: 2];
			mains_lock_enable_o <= GLOB_RST[MAINS_LOCK_ENABLE_BIT];
			burst_spacing_o <= SPACE_RST[3:0];
			uart_baud_select_o <= SPACE_RST[7:4];
			lower_signal_limit_o <= LSL_RST;
		end else begin
			release_hysteresis_o <= glob[3:0];
			dwell_select_o <= glob[DWELL_LSB +: 2];
			mains_lock_enable_o <= glob[MAINS_LOCK_ENABLE_BIT];
			burst_spacing_o <= space[3:0];
			uart_baud_select_o <= space[7:4];
			lower_signal_limit_o <= minimum_signal_level;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!nrst_i)
			key_low_signal_o <= '0;
		else if (key_signal_valid_i && key_signal_key_i < 6'(NKEYS))
			key_low_signal_o[key_signal_key_i] <= key_signal_i < minimum_signal_level;
	end

	// wait window opens at the end of each full scan
	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			mains_prev <= 1'b1;
			mains_wait <= 1'b0;
			mains_ms <= '0;
		end else begin
			mains_prev <= mains_sync_i;
			if (mains_fall || !glob[MAINS_LOCK_ENABLE_BIT]) begin
				mains_wait <= 1'b0;
				mains_ms <= '0;
			end else if (scan_done_i) begin
				mains_wait <= 1'b1;
				mains_ms <= '0;
			end else if (mains_wait && mains_ms == MS_W'(MAINS_MS)) begin
				// one-shot timeout, so the next falling edge can clear
				mains_wait <= 1'b0;
			end else if (mains_wait && tick &&
				mains_ms != MS_W'(MAINS_MS)) begin
				mains_ms <= mains_ms + 1'b1;
			end
		end
	end

	// timeout wins over a falling edge in the same cycle
	always_ff @(posedge core_clk_i) begin
		if (!nrst_i || !glob[MAINS_LOCK_ENABLE_BIT])
			mains_sync_error_o <= 1'b0;
		else if (mains_wait && mains_ms == MS_W'(MAINS_MS))
			mains_sync_error_o <= 1'b1;
		else if (mains_fall)
			mains_sync_error_o <= 1'b0;
	end

	assign al.ctrl = alert_ctrl;
	assign al.key_err = cal_error_i || (|key_low_signal_o);
	assign al.press = |key_touch_i;
	assign al.sleep = sleep_i;
	assign al.nvm_err = nvm_error_i;
	assign al.mains_err = mains_sync_error_o;
	assign al.comms_bad = host_cmd_bad_i;
	assign al.get_last = host_get_last_i;
	assign al.host_cmd = host_cmd_valid_i;
	assign al.host_act = host_cmd_valid_i || host_cmd_bad_i || setup_valid_i;
	assign al.tick = tick;
	assign alert_o = al.alert;

	tmk_alert u_alert (
		.core_clk_i(core_clk_i),
		.nrst_i(nrst_i),
		.al(al)
	);

	tmk_report u_report (
		.core_clk_i(core_clk_i),
		.nrst_i(nrst_i),
		.start_i(host_cmd_valid_i && host_cmd_i == CMD_REPORT_KEYS &&
			!setups_mode_o),
		.flags_i(key_touch_i),
		.ready_i(report_ready_i),
		.valid_o(report_valid_o),
		.byte_o(report_byte_o)
	);
endmodule
`default_nettype wire
